/* File: rtl/flash_pkg.sv */
// constants, field layout and types for the flash level and timeout registers
// Contract
// - led1 flash code is current register bits 3:0 at 0xB0, independent of led2
// - led2 flash code is current register bits 7:4
// - flash level is (code+1) times 62.5 mA, 62.5 mA up to 1000 mA
// - both flash nibbles reset to 1101, 875 mA per led
// - timeout code is timeout register bits 4:0 at 0xC0
// - timeout lasts (code+1) times 32 ms, 32 ms up to 1024 ms
// - timeout code resets to 01111, 512 ms
// - peak switch current limit code is timeout register bits 6:5
// - timeout expiry sets a flag; reading the flags register clears it unless an expiry comes in the same cycle
package flash_pkg;
	localparam logic [7:0] ADDR_CURRENT = 8'hB0;
	localparam logic [7:0] ADDR_TIMEOUT = 8'hC0;
	localparam logic [7:0] ADDR_FLAGS = 8'hD0;
	localparam int LED1_LSB = 0;
	localparam int LED2_LSB = 4;
	localparam int TMO_LSB = 0;
	localparam int LIM_LSB = 5;
	localparam int FLAG_TIMEOUT_BIT = 0;
	localparam logic [3:0] CURRENT_RST = 4'hD;
	localparam logic [4:0] TMO_RST = 5'h0F;
	localparam logic [1:0] LIM_RST = 2'h3;
	localparam int STEP_UA = 62500;
	localparam int TIMEOUT_STEP_MS = 32;
	localparam int CLK_HZ = 10000000;
	localparam int STEP_CYCLES = TIMEOUT_STEP_MS * (CLK_HZ / 1000);
	localparam logic [11:0] LIMIT_MA0 = 12'h640;
	localparam logic [11:0] LIMIT_MA1 = 12'h8FC;
	localparam logic [11:0] LIMIT_MA2 = 12'hBB8;
	localparam logic [11:0] LIMIT_MA3 = 12'hE10;
	typedef enum logic [1:0] {
		TMR_IDLE = 2'b01,
		TMR_RUN = 2'b10
	} timer_state_e;
endpackage

/* File: rtl/flash_timer_if.sv */
// signals between the register bank and the flash timeout timer
interface flash_timer_if;
	logic start;
	logic stop;
	logic [4:0] code;
	logic active;
	logic expired;
	modport ctrl (output start, output stop, output code, input active, input expired);
	modport timer (input start, input stop, input code, output active, output expired);
endinterface

/* File: rtl/flash_timer.sv */
// flash timeout timer, counts (code+1) steps of one timeout step each
module flash_timer #(
	parameter int STEP_CYCLES = flash_pkg::STEP_CYCLES
) (
	input wire logic sys_clk,
	input wire logic rst,
	flash_timer_if.timer tif
);
	typedef struct packed {
		flash_pkg::timer_state_e state;
		logic [23:0] stepCnt;
		logic [4:0] stepsLeft;
		logic expired;
	} timer_s;

	timer_s q, d;

	always_comb begin
		d = q;
		d.expired = 1'b0;
		unique case (q.state)
			flash_pkg::TMR_IDLE: begin
				if (tif.start) begin
					d.state = flash_pkg::TMR_RUN;
					d.stepCnt = '0;
					d.stepsLeft = tif.code; // code latched, later writes wait for next pulse
				end
			end
			flash_pkg::TMR_RUN: begin
				if (tif.stop) begin
					d.state = flash_pkg::TMR_IDLE;
				end else if (q.stepCnt == 24'(STEP_CYCLES - 1)) begin
					d.stepCnt = '0;
					if (q.stepsLeft == 5'h00) begin
						d.state = flash_pkg::TMR_IDLE;
						d.expired = 1'b1;
					end else begin
						d.stepsLeft = q.stepsLeft - 5'h01;
					end
				end else begin
					d.stepCnt = q.stepCnt + 24'h000001;
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			q <= '{state: flash_pkg::TMR_IDLE, stepCnt: '0, stepsLeft: '0, expired: 1'b0};
		end else begin
			q <= d;
		end
	end

	assign tif.active = (q.state == flash_pkg::TMR_RUN);
	assign tif.expired = q.expired;

	// helper: cycles spent in the current pulse and the code it began with
	logic [31:0] elapsed;
	logic [4:0] startCode;
	always_ff @(posedge sys_clk) begin
		if (rst || !tif.active) begin
			elapsed <= '0;
		end else begin
			elapsed <= elapsed + 32'h00000001;
		end
		if (!tif.active && tif.start) begin
			startCode <= tif.code;
		end
	end

	a_expire_duration: assert property (@(posedge sys_clk) disable iff (rst)
		$rose(q.expired) |-> $past(elapsed) == 32'((32'(startCode) + 1) * STEP_CYCLES - 1))
		else $error("timeout did not last (code+1) steps");
	a_start_runs: assert property (@(posedge sys_clk) disable iff (rst)
		(!tif.active && tif.start) |=> tif.active && !tif.expired)
		else $error("flash pulse did not start the timer");
	a_expire_ends: assert property (@(posedge sys_clk) disable iff (rst)
		tif.expired |-> !tif.active ##1 !tif.expired)
		else $error("expiry did not end the pulse");
endmodule

/* File: rtl/flash_level_timeout_regs.sv */
// flash current and flash timeout registers with decode and timeout flag
module flash_level_timeout_regs #(
	parameter int STEP_CYCLES = flash_pkg::STEP_CYCLES
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrEn,
	input wire logic regRdEn,
	output logic [7:0] regRdData,
	input wire logic flashStart,
	input wire logic flashStop,
	output logic flashActive,
	output logic [3:0] led1_flash_code,
	output logic [3:0] led2_flash_code,
	output logic [19:0] led1CurrentUa,
	output logic [19:0] led2CurrentUa,
	output logic [4:0] timeout_sel,
	output logic [10:0] timeoutMs,
	output logic [1:0] limit_sel,
	output logic [11:0] limitMa,
	output logic timeoutFlag
);
	typedef struct packed {
		logic [7:0] current;
		logic [6:0] tmoLim;
		logic timeoutFlag;
		logic [7:0] rdData;
		logic [19:0] led1Ua;
		logic [19:0] led2Ua;
		logic [10:0] tmoMs;
		logic [11:0] limMa;
	} regs_s;

	regs_s q, d;
	flash_timer_if tif ();

	flash_timer #(.STEP_CYCLES(STEP_CYCLES)) timer (
		.sys_clk(sys_clk),
		.rst(rst),
		.tif(tif)
	);

	assign tif.start = flashStart;
	assign tif.stop = flashStop;
	assign tif.code = q.tmoLim[flash_pkg::TMO_LSB +: 5];

	function automatic logic [19:0] level_ua(input logic [3:0] code);
		level_ua = 20'((32'(code) + 1) * flash_pkg::STEP_UA);
	endfunction

	always_comb begin
		d = q;
		if (regWrEn) begin
			unique case (regAddr)
				flash_pkg::ADDR_CURRENT: d.current = regWrData;
				flash_pkg::ADDR_TIMEOUT: d.tmoLim = regWrData[6:0];
				default: ;
			endcase
		end
		// reading clears, but an expiry in the same cycle wins
		if (regRdEn && regAddr == flash_pkg::ADDR_FLAGS) begin
			d.timeoutFlag = 1'b0;
		end
		if (tif.expired) begin
			d.timeoutFlag = 1'b1;
		end
		if (regRdEn) begin
			unique case (regAddr)
				flash_pkg::ADDR_CURRENT: d.rdData = q.current;
				flash_pkg::ADDR_TIMEOUT: d.rdData = {1'b0, q.tmoLim};
				flash_pkg::ADDR_FLAGS: d.rdData = 8'(q.timeoutFlag) << flash_pkg::FLAG_TIMEOUT_BIT;
				default: d.rdData = 8'h00;
			endcase
		end
		d.led1Ua = level_ua(q.current[flash_pkg::LED1_LSB +: 4]);
		d.led2Ua = level_ua(q.current[flash_pkg::LED2_LSB +: 4]);
		d.tmoMs = 11'((32'(q.tmoLim[flash_pkg::TMO_LSB +: 5]) + 1) * flash_pkg::TIMEOUT_STEP_MS);
		unique case (q.tmoLim[flash_pkg::LIM_LSB +: 2])
			2'h0: d.limMa = flash_pkg::LIMIT_MA0;
			2'h1: d.limMa = flash_pkg::LIMIT_MA1;
			2'h2: d.limMa = flash_pkg::LIMIT_MA2;
			2'h3: d.limMa = flash_pkg::LIMIT_MA3;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			q.current <= {flash_pkg::CURRENT_RST, flash_pkg::CURRENT_RST};
			q.tmoLim <= {flash_pkg::LIM_RST, flash_pkg::TMO_RST};
			q.timeoutFlag <= 1'b0;
			q.rdData <= 8'h00;
			q.led1Ua <= 20'((32'(flash_pkg::CURRENT_RST) + 1) * flash_pkg::STEP_UA);
			q.led2Ua <= 20'((32'(flash_pkg::CURRENT_RST) + 1) * flash_pkg::STEP_UA);
			q.tmoMs <= 11'((32'(flash_pkg::TMO_RST) + 1) * flash_pkg::TIMEOUT_STEP_MS);
			q.limMa <= flash_pkg::LIMIT_MA3;
		end else begin
			q <= d;
		end
	end

	assign regRdData = q.rdData;
	assign flashActive = tif.active;
	assign led1_flash_code = q.current[flash_pkg::LED1_LSB +: 4];
	assign led2_flash_code = q.current[flash_pkg::LED2_LSB +: 4];
	assign led1CurrentUa = q.led1Ua;
	assign led2CurrentUa = q.led2Ua;
	assign timeout_sel = q.tmoLim[flash_pkg::TMO_LSB +: 5];
	assign timeoutMs = q.tmoMs;
	assign limit_sel = q.tmoLim[flash_pkg::LIM_LSB +: 2];
	assign limitMa = q.limMa;
	assign timeoutFlag = q.timeoutFlag;

	a_reset_defaults: assert property (@(posedge sys_clk)
		rst |=> led1_flash_code == 4'hD && led2_flash_code == 4'hD && timeout_sel == 5'h0F
			&& limit_sel == 2'h3 && !timeoutFlag)
		else $error("wrong values after reset");
	a_led1_independent: assert property (@(posedge sys_clk) disable iff (rst)
		(regWrEn && regAddr == 8'hB0) |=> led1_flash_code == $past(regWrData[3:0])
			&& led2_flash_code == $past(regWrData[7:4]))
		else $error("flash current write not split into nibbles");
	a_level_decode: assert property (@(posedge sys_clk) disable iff (rst)
		$stable(led1_flash_code) |=> led1CurrentUa
			== 20'((32'($past(led1_flash_code)) + 1) * flash_pkg::STEP_UA))
		else $error("led1 flash level decode wrong");
	a_timeout_decode: assert property (@(posedge sys_clk) disable iff (rst)
		(regWrEn && regAddr == 8'hC0) ##1 !regWrEn [*2] |-> timeoutMs == 11'((32'(timeout_sel) + 1) * 32))
		else $error("timeout decode wrong");
	a_limit_decode: assert property (@(posedge sys_clk) disable iff (rst)
		(regWrEn && regAddr == 8'hC0 && regWrData[6:5] == 2'h0) ##1 !regWrEn |=> limitMa == 12'h640)
		else $error("limit decode wrong");
	a_flag_set: assert property (@(posedge sys_clk) disable iff (rst)
		tif.expired |=> timeoutFlag)
		else $error("expiry did not set the flag");
	a_flag_clear: assert property (@(posedge sys_clk) disable iff (rst)
		(regRdEn && regAddr == 8'hD0 && !tif.expired) |=> !timeoutFlag
			&& regRdData[0] == $past(timeoutFlag))
		else $error("flags read did not clear and report");
	a_bit7_unused: assert property (@(posedge sys_clk) disable iff (rst)
		(regRdEn && regAddr == 8'hC0) |=> !regRdData[7])
		else $error("unused bit read back set");

	// decoded outputs lag their codes by one cycle, so these checks look one cycle back
	a_led2_decode: assert property (@(posedge sys_clk) disable iff (rst)
		1'b1 |=> led2CurrentUa
			== 20'((32'($past(led2_flash_code)) + 1) * flash_pkg::STEP_UA))
		else $error("led2 flash level decode wrong");

	a_reset_decode: assert property (@(posedge sys_clk)
		rst |=> led1CurrentUa == 20'hD59F8 && led2CurrentUa == 20'hD59F8 && timeoutMs == 11'h200
			&& limitMa == 12'hE10 && !flashActive && regRdData == 8'h00)
		else $error("decoded values wrong after reset");

	a_current_hold: assert property (@(posedge sys_clk) disable iff (rst)
		!(regWrEn && regAddr == flash_pkg::ADDR_CURRENT)
			|=> $stable(led1_flash_code) && $stable(led2_flash_code))
		else $error("flash current changed without a write");

	a_read_current: assert property (@(posedge sys_clk) disable iff (rst)
		(regRdEn && regAddr == flash_pkg::ADDR_CURRENT) |=> regRdData[3:0] == $past(led1_flash_code)
			&& regRdData[7:4] == $past(led2_flash_code))
		else $error("flash current read back wrong");

	a_timeout_write: assert property (@(posedge sys_clk) disable iff (rst)
		(regWrEn && regAddr == flash_pkg::ADDR_TIMEOUT) |=> timeout_sel == $past(regWrData[4:0]))
		else $error("timeout code not taken from bits 4:0");

	a_timeout_hold: assert property (@(posedge sys_clk) disable iff (rst)
		!(regWrEn && regAddr == flash_pkg::ADDR_TIMEOUT)
			|=> $stable(timeout_sel) && $stable(limit_sel))
		else $error("timeout register changed without a write");

	a_read_timeout: assert property (@(posedge sys_clk) disable iff (rst)
		(regRdEn && regAddr == flash_pkg::ADDR_TIMEOUT) |=> regRdData[4:0] == $past(timeout_sel)
			&& regRdData[6:5] == $past(limit_sel))
		else $error("timeout register read back wrong");

	a_timeout_every: assert property (@(posedge sys_clk) disable iff (rst)
		1'b1 |=> timeoutMs
			== 11'((32'($past(timeout_sel)) + 1) * flash_pkg::TIMEOUT_STEP_MS))
		else $error("timeout duration decode wrong");

	a_limit_write: assert property (@(posedge sys_clk) disable iff (rst)
		(regWrEn && regAddr == flash_pkg::ADDR_TIMEOUT) |=> limit_sel == $past(regWrData[6:5]))
		else $error("limit code not taken from bits 6:5");

	a_limit_table: assert property (@(posedge sys_clk) disable iff (rst)
		1'b1 |=> ($past(limit_sel) == 2'h0 && limitMa == 12'h640)
			|| ($past(limit_sel) == 2'h1 && limitMa == 12'h8FC)
			|| ($past(limit_sel) == 2'h2 && limitMa == 12'hBB8)
			|| ($past(limit_sel) == 2'h3 && limitMa == 12'hE10))
		else $error("limit decode table wrong");

	a_read_flags: assert property (@(posedge sys_clk) disable iff (rst)
		(regRdEn && regAddr == flash_pkg::ADDR_FLAGS) |=> regRdData[7:1] == 7'h00)
		else $error("unused flag bits read back set");

	a_flag_holds: assert property (@(posedge sys_clk) disable iff (rst)
		(!tif.expired && !(regRdEn && regAddr == flash_pkg::ADDR_FLAGS))
			|=> $stable(timeoutFlag))
		else $error("timeout flag changed without expiry or read");

	a_flag_cause: assert property (@(posedge sys_clk) disable iff (rst)
		$rose(timeoutFlag) |-> $past(tif.expired))
		else $error("timeout flag set without expiry");

	a_stop_ends: assert property (@(posedge sys_clk) disable iff (rst)
		(flashActive && flashStop) |=> !flashActive && !tif.expired)
		else $error("stop did not end the pulse quietly");

	a_fall_cause: assert property (@(posedge sys_clk) disable iff (rst)
		$fell(flashActive) |-> tif.expired || $past(flashStop))
		else $error("pulse ended without expiry or stop");

	a_start_ignored: assert property (@(posedge sys_clk) disable iff (rst)
		(flashActive && flashStart && !flashStop) |=> flashActive || tif.expired)
		else $error("start during a pulse disturbed it");

	a_stop_idle: assert property (@(posedge sys_clk) disable iff (rst)
		(!flashActive && flashStop && !flashStart) |=> !flashActive)
		else $error("stop while idle started a pulse");

	a_idle_quiet: assert property (@(posedge sys_clk) disable iff (rst)
		!flashActive |=> !tif.expired)
		else $error("expiry reported while idle");
endmodule

/* File: tb/host_model.sv */
// host controller model driving register strobes and flash pulse requests
module host_model (
	input wire logic sys_clk,
	output logic [7:0] regAddr,
	output logic [7:0] regWrData,
	output logic regWrEn,
	output logic regRdEn,
	input wire logic [7:0] regRdData,
	output logic flashStart,
	output logic flashStop
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		regAddr = 8'h00;
		regWrData = 8'h00;
		regWrEn = 1'b0;
		regRdEn = 1'b0;
		flashStart = 1'b0;
		flashStop = 1'b0;
	end
	// released bus shows inverted values so stale data never looks valid
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		regAddr <= a;
		regWrData <= d;
		regWrEn <= 1'b1;
		@(posedge sys_clk);
		regWrEn <= 1'b0;
		regAddr <= ~a;
		regWrData <= ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		regAddr <= a;
		regRdEn <= 1'b1;
		@(posedge sys_clk);
		regRdEn <= 1'b0;
		regAddr <= ~a;
		#1;
		d = regRdData;
	endtask
	task automatic pulse(input logic stop);
		@(posedge sys_clk);
		flashStart <= ~stop;
		flashStop <= stop;
		@(posedge sys_clk);
		flashStart <= 1'b0;
		flashStop <= 1'b0;
	endtask
endmodule

/* File: tb/tb_top.sv */
// testbench for the flash level and timeout register bank
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] regAddr, regWrData, regRdData;
	logic regWrEn, regRdEn, flashStart, flashStop, flashActive, timeoutFlag;
	logic [3:0] led1_flash_code, led2_flash_code;
	logic [19:0] led1CurrentUa, led2CurrentUa;
	logic [4:0] timeout_sel;
	logic [10:0] timeoutMs;
	logic [1:0] limit_sel;
	logic [11:0] limitMa;
	logic [19:0] limTab [4] = '{20'h00640, 20'h008FC, 20'h00BB8, 20'h00E10};
	int errors = 0;
	int checked = 0;
	always #50 sys_clk = ~sys_clk;
	host_model host (
		.sys_clk(sys_clk),
		.regAddr(regAddr),
		.regWrData(regWrData),
		.regWrEn(regWrEn),
		.regRdEn(regRdEn),
		.regRdData(regRdData),
		.flashStart(flashStart),
		.flashStop(flashStop)
	);
	// short step keeps the longest pulse to 128 cycles
	flash_level_timeout_regs #(.STEP_CYCLES(4)) uut (
		.sys_clk(sys_clk),
		.rst(rst),
		.regAddr(regAddr),
		.regWrData(regWrData),
		.regWrEn(regWrEn),
		.regRdEn(regRdEn),
		.regRdData(regRdData),
		.flashStart(flashStart),
		.flashStop(flashStop),
		.flashActive(flashActive),
		.led1_flash_code(led1_flash_code),
		.led2_flash_code(led2_flash_code),
		.led1CurrentUa(led1CurrentUa),
		.led2CurrentUa(led2CurrentUa),
		.timeout_sel(timeout_sel),
		.timeoutMs(timeoutMs),
		.limit_sel(limit_sel),
		.limitMa(limitMa),
		.timeoutFlag(timeoutFlag)
	);
	function automatic logic [19:0] ua(input int c);
		return 20'((c + 1) * flash_pkg::STEP_UA);
	endfunction
	task automatic chk(input logic [19:0] got, input logic [19:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic finish_test();
		$display("errors %0d checked %0d", errors, checked);
		if (errors == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	initial begin
		logic [7:0] d;
		int n;
		repeat (12) @(posedge sys_clk);
		rst <= 1'b0;
		#1;
		chk(led1_flash_code, 20'h0000D);
		chk(led2CurrentUa, 20'hD59F8);
		chk(timeoutMs, 20'h00200);
		chk(limitMa, 20'h00E10);
		chk(flashActive, 20'h00000);
		chk(timeoutFlag, 20'h00000);
		host.rd(8'hB0, d);
		chk(d, 20'h000DD);
		host.rd(8'hC0, d);
		chk(d, 20'h0006F);
		host.rd(8'h55, d);
		chk(d, 20'h00000);
		for (int i = 0; i < 16; i++) begin
			host.wr(8'hB0, {4'(15 - i), 4'(i)});
			@(posedge sys_clk);
			#1;
			chk(led1_flash_code, 20'(i));
			chk(led2_flash_code, 20'(15 - i));
			chk(led1CurrentUa, ua(i));
			chk(led2CurrentUa, ua(15 - i));
		end
		host.wr(8'h55, 8'hAA);
		host.rd(8'hB0, d);
		chk(d, 20'h0000F);
		for (int t = 0; t < 32; t++) begin
			host.wr(8'hC0, {1'b1, 2'(t), 5'(t)});
			@(posedge sys_clk);
			#1;
			chk(timeout_sel, 20'(t));
			chk(timeoutMs, 20'((t + 1) * 32));
			chk(limit_sel, 20'(t % 4));
			chk(limitMa, limTab[t % 4]);
			host.rd(8'hC0, d);
			chk(d, 20'({2'(t), 5'(t)}));
		end
		host.wr(8'hC0, 8'h62);
		host.pulse(1'b0);
		#1;
		n = 0;
		while (flashActive === 1'b1 && n < 50) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		if (n == 50) begin
			errors++;
			finish_test();
		end
		chk(20'(n), 20'h0000C);
		@(posedge sys_clk);
		#1;
		chk(timeoutFlag, 20'h00001);
		host.rd(8'hD0, d);
		chk(d, 20'h00001);
		chk(timeoutFlag, 20'h00000);
		host.pulse(1'b0);
		#1;
		chk(flashActive, 20'h00001);
		host.pulse(1'b0);
		#1;
		chk(flashActive, 20'h00001);
		host.pulse(1'b1);
		@(posedge sys_clk);
		#1;
		chk(flashActive, 20'h00000);
		chk(timeoutFlag, 20'h00000);
		host.pulse(1'b1);
		@(posedge sys_clk);
		#1;
		chk(flashActive, 20'h00000);
		finish_test();
	end
endmodule
